// ==== logic/tpg_pkg.sv ====
// Package with the constants, types and register map of the triggered pulse generator.
package tpg_pkg;

  // Timebase: settings are held in 10 ns units and the 20 ns clock removes two units per cycle.
  localparam int CLK_PERIOD_NS = 20;
  localparam int UNIT_NS = 10;
  localparam int TICK_UNITS = CLK_PERIOD_NS / UNIT_NS;
  localparam int VAL_W = 27;

  // Setting ranges in nanoseconds as printed.
  localparam int DELAY_MIN_NS = 100;
  localparam int DELAY_MAX_NS = 1000000000;
  localparam int DSTEP_MIN_NS = 10;
  localparam int DSTEP_MAX_NS = 500000000;
  localparam int WIDTH_MIN_NS = 50;
  localparam int WIDTH_MAX_NS = 10000000;
  localparam int WSTEP_MIN_NS = 10;
  localparam int WSTEP_MAX_NS = 5000000;
  localparam int SYNC_MIN_NS = 0;
  localparam int SYNC_MAX_NS = 10000000;
  localparam int SSTEP_MIN_NS = 10;
  localparam int SSTEP_MAX_NS = 5000000;
  localparam int SYNC_PULSE_NS = 100;

  // Least values round up, longest values round down to whole units.
  localparam int DELAY_MIN_U = (DELAY_MIN_NS + UNIT_NS - 1) / UNIT_NS;
  localparam int DSTEP_MIN_U = (DSTEP_MIN_NS + UNIT_NS - 1) / UNIT_NS;
  localparam int DSTEP_MAX_U = DSTEP_MAX_NS / UNIT_NS;
  localparam int WIDTH_MIN_U = (WIDTH_MIN_NS + UNIT_NS - 1) / UNIT_NS;
  localparam int WSTEP_MIN_U = (WSTEP_MIN_NS + UNIT_NS - 1) / UNIT_NS;
  localparam int WSTEP_MAX_U = WSTEP_MAX_NS / UNIT_NS;
  localparam int SYNC_MIN_U = (SYNC_MIN_NS + UNIT_NS - 1) / UNIT_NS;
  localparam int SSTEP_MIN_U = (SSTEP_MIN_NS + UNIT_NS - 1) / UNIT_NS;
  localparam int SSTEP_MAX_U = SSTEP_MAX_NS / UNIT_NS;
  localparam logic [VAL_W-1:0] SYNC_PULSE_U = VAL_W'((SYNC_PULSE_NS + UNIT_NS - 1) / UNIT_NS);

  // Register offsets (byte addresses).
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DELAY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WIDTH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SYNC = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DSTEP = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_WSTEP = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SSTEP = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STEPCMD = 8'h20;

  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int STAT_MOD_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_VIDEO_BIT = 2;
  localparam int STAT_SYNC_BIT = 3;
  localparam int STAT_MISS_BIT = 4;
  localparam int CMD_SEL_LSB = 0;
  localparam int CMD_DOWN_BIT = 2;

  typedef enum logic [1:0] {
    TPG_MODE_EXT = 2'h0,
    TPG_MODE_CONT = 2'h1,
    TPG_MODE_TRIG = 2'h2,
    TPG_MODE_GATE = 2'h3
  } tpg_mode_t;

  typedef enum logic [1:0] {
    TPG_IDLE = 2'h0,
    TPG_DELAY = 2'h1,
    TPG_PULSE = 2'h3
  } tpg_state_t;

  typedef struct packed {
    logic mod_en;
    tpg_mode_t mode;
    logic fall_edge;
    logic [VAL_W-1:0] delay;
    logic [VAL_W-1:0] width;
    logic [VAL_W-1:0] sync_dly;
  } tpg_cfg_t;

  // Values after reset, in units.
  localparam logic [VAL_W-1:0] DELAY_RST = 27'h000000A;
  localparam logic [VAL_W-1:0] WIDTH_RST = 27'h0000064;
  localparam logic [VAL_W-1:0] SYNC_RST = 27'h0000000;
  localparam logic [VAL_W-1:0] STEP_RST = 27'h0000001;
  localparam tpg_mode_t MODE_RST = TPG_MODE_TRIG;

endpackage

// ==== logic/tpg_counter.sv ====
// Down-counter that removes a fixed number of units per clock and flags the last cycle.
module tpg_counter import tpg_pkg::*; #(
  parameter int W = VAL_W,
  parameter int STEP = TICK_UNITS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  // Status.
  output logic [W-1:0] rem,
  output logic done
);

  // A remainder at or below one step means the interval ends at the coming edge.
  assign done = (rem <= W'(STEP));

  // Load wins over counting; the count parks once it reaches the last step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem <= '0;
    end else if (load) begin
      rem <= load_val;
    end else if (run && !done) begin
      rem <= rem - W'(STEP);
    end
  end

endmodule

// ==== logic/tpg_top.sv ====
// Triggered pulse generator with APB register access, video and sync outputs.
// Overview of operation
// - Triggered mode and enabled: one pulse per accepted trigger edge.
// - Edge select picks rising or falling trigger edge; the other is ignored.
// - Trigger edge to video rise is one 20 ns sampling clock plus the programmed delay rounded up to 20 ns, 100 ns to 1000 ms.
// - Delay step increment is programmable from 10 ns to 500 ms.
// - Video pulse width is 50 ns to 10 ms, step 10 ns to 5 ms.
// - Sync pulse follows the video rise by the programmed sync delay.
// - Sync delay spans 0 ns to 10 ms with its own step increment.
// - Enable only gates modulation; mode comes from a separate field, acting at once.
// - Status output is a registered copy of modulation enable, one clock behind it.
// - One width register serves triggered mode; continuous and gated modes make no pulse.
//
// The APB register port and the placing of the registers were chosen for this implementation.
module tpg_top import tpg_pkg::*; #(
  parameter int DELAY_MAX_NS_P = DELAY_MAX_NS,
  parameter int WIDTH_MAX_NS_P = WIDTH_MAX_NS,
  parameter int SYNC_MAX_NS_P = SYNC_MAX_NS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger and pulse outputs.
  input wire logic trigger_input,
  output logic video_pulse_output,
  output logic sync_pulse_output,
  output logic modulation_status
);

  // Range limits in units; the long maxima are parameters so a bench can shrink them.
  localparam logic [31:0] DLY_LO = 32'(DELAY_MIN_U);
  localparam logic [31:0] DLY_HI = 32'(DELAY_MAX_NS_P / UNIT_NS);
  localparam logic [31:0] WID_LO = 32'(WIDTH_MIN_U);
  localparam logic [31:0] WID_HI = 32'(WIDTH_MAX_NS_P / UNIT_NS);
  localparam logic [31:0] SYN_LO = 32'(SYNC_MIN_U);
  localparam logic [31:0] SYN_HI = 32'(SYNC_MAX_NS_P / UNIT_NS);

  // Clamp a value into a range and cut it to the register width.
  function automatic logic [VAL_W-1:0] clampv(input logic [31:0] v, input logic [31:0] lo,
                                                input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r[VAL_W-1:0];
  endfunction

  // Move a setting by its step; going down never wraps below zero before clamping.
  function automatic logic [VAL_W-1:0] stepv(input logic [VAL_W-1:0] cur, input logic [VAL_W-1:0] stp,
                                               input logic down, input logic [31:0] lo,
                                               input logic [31:0] hi);
    logic [31:0] r;
    r = {5'h00, cur} + {5'h00, stp};
    if (down) begin
      r = (cur > stp) ? {5'h00, cur - stp} : 32'h00000000;
    end
    return clampv(r, lo, hi);
  endfunction

  // Register state.
  logic en_q;
  tpg_mode_t mode_q;
  logic edge_q;
  logic [VAL_W-1:0] dly_q, wid_q, syn_q, dst_q, wst_q, sst_q;
  logic [VAL_W-1:0] dly_d, wid_d, syn_d, dst_d, wst_d, sst_d;
  logic miss_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  // Pulse engine state.
  tpg_state_t st_q, st_d;
  logic trig_prev_q;
  logic video_q, video_d;
  logic sync_q, sync_wait_q;
  logic mod_status_q;
  tpg_cfg_t cfg;

  // Counter hookups.
  logic main_load, main_done, sync_load, sync_done;
  logic [VAL_W-1:0] main_val, sync_val, main_rem, sync_rem;

  // APB decode: the transfer completes on the access cycle where pready_q is high.
  wire setup = psel && !penable;
  wire done_xfer = psel && penable && pready_q;
  wire wr = done_xfer && pwrite;
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_stat = (paddr == OFF_STATUS);
  wire hit_dly = (paddr == OFF_DELAY);
  wire hit_wid = (paddr == OFF_WIDTH);
  wire hit_syn = (paddr == OFF_SYNC);
  wire hit_dst = (paddr == OFF_DSTEP);
  wire hit_wst = (paddr == OFF_WSTEP);
  wire hit_sst = (paddr == OFF_SSTEP);
  wire hit_cmd = (paddr == OFF_STEPCMD);
  wire mapped = hit_ctrl | hit_stat | hit_dly | hit_wid | hit_syn | hit_dst | hit_wst | hit_sst | hit_cmd;
  wire [1:0] cmd_sel = pwdata[CMD_SEL_LSB +: 2];
  wire cmd_down = pwdata[CMD_DOWN_BIT];
  wire cmd_go = wr && hit_cmd;

  // Direct writes clamp into range; step commands move a setting by its own step.
  assign dly_d = (wr && hit_dly) ? clampv(pwdata, DLY_LO, DLY_HI) :
                 (cmd_go && cmd_sel == 2'h0) ? stepv(dly_q, dst_q, cmd_down, DLY_LO, DLY_HI) : dly_q;
  assign wid_d = (wr && hit_wid) ? clampv(pwdata, WID_LO, WID_HI) :
                 (cmd_go && cmd_sel == 2'h1) ? stepv(wid_q, wst_q, cmd_down, WID_LO, WID_HI) : wid_q;
  assign syn_d = (wr && hit_syn) ? clampv(pwdata, SYN_LO, SYN_HI) :
                 (cmd_go && cmd_sel == 2'h2) ? stepv(syn_q, sst_q, cmd_down, SYN_LO, SYN_HI) : syn_q;
  assign dst_d = (wr && hit_dst) ? clampv(pwdata, 32'(DSTEP_MIN_U), 32'(DSTEP_MAX_U)) : dst_q;
  assign wst_d = (wr && hit_wst) ? clampv(pwdata, 32'(WSTEP_MIN_U), 32'(WSTEP_MAX_U)) : wst_q;
  assign sst_d = (wr && hit_sst) ? clampv(pwdata, 32'(SSTEP_MIN_U), 32'(SSTEP_MAX_U)) : sst_q;

  // Read mux, sampled in the setup cycle so the data stand through the access phase.
  wire [31:0] rd_mux =
    hit_ctrl ? {28'h0000000, edge_q, mode_q, en_q} :
    hit_stat ? {27'h0000000, miss_q, sync_q, video_q, (st_q != TPG_IDLE) | sync_wait_q | sync_q, mod_status_q} :
    hit_dly ? {5'h00, dly_q} :
    hit_wid ? {5'h00, wid_q} :
    hit_syn ? {5'h00, syn_q} :
    hit_dst ? {5'h00, dst_q} :
    hit_wst ? {5'h00, wst_q} :
    hit_sst ? {5'h00, sst_q} : 32'h00000000;

  // APB answer: one wait state, pready and pslverr registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      if (setup) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_q <= !mapped;
      end
    end
  end

  // Settings; a single width register feeds triggered mode, the only mode that times a pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      mode_q <= MODE_RST;
      edge_q <= 1'b0;
      dly_q <= DELAY_RST;
      wid_q <= WIDTH_RST;
      syn_q <= SYNC_RST;
      dst_q <= STEP_RST;
      wst_q <= STEP_RST;
      sst_q <= STEP_RST;
    end else begin
      if (wr && hit_ctrl) begin
        en_q <= pwdata[CTRL_EN_BIT];
        mode_q <= tpg_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
        edge_q <= pwdata[CTRL_EDGE_BIT];
      end
      dly_q <= dly_d;
      wid_q <= wid_d;
      syn_q <= syn_d;
      dst_q <= dst_d;
      wst_q <= wst_d;
      sst_q <= sst_d;
    end
  end

  // Settings gathered into one carrier; a single assignment keeps the variable to one driver.
  assign cfg = '{
    mod_en: en_q,
    mode: mode_q,
    fall_edge: edge_q,
    delay: dly_q,
    width: wid_q,
    sync_dly: syn_q
  };

  // Trigger edge detection; the input is taken as already synchronous.
  wire rise_edge = trigger_input && !trig_prev_q;
  wire fall_edge = !trigger_input && trig_prev_q;
  wire sel_edge = cfg.fall_edge ? fall_edge : rise_edge;
  wire trig_mode = cfg.mod_en && (cfg.mode == TPG_MODE_TRIG);
  wire ext_mode = cfg.mod_en && (cfg.mode == TPG_MODE_EXT);
  wire sync_busy = sync_wait_q || sync_q;
  // A trigger is taken only with the engine idle, so each one yields one full pulse.
  wire accept = trig_mode && sel_edge && (st_q == TPG_IDLE) && !sync_busy;
  wire missed = trig_mode && sel_edge && !accept;
  wire vid_rise = trig_mode && (st_q == TPG_DELAY) && main_done;

  // Engine: a mode change or disable drops it to idle at the next edge.
  always_comb begin
    st_d = st_q;
    case (st_q)
      TPG_IDLE: if (accept) st_d = TPG_DELAY;
      TPG_DELAY: if (main_done) st_d = TPG_PULSE;
      TPG_PULSE: if (main_done) st_d = TPG_IDLE;
      default: st_d = TPG_IDLE;
    endcase
    if (!trig_mode) begin
      st_d = TPG_IDLE;
    end
  end

  // The main counter times the delay, then is reloaded with the width at the video rise.
  assign main_load = accept || vid_rise;
  assign main_val = accept ? cfg.delay : cfg.width;
  // The sync counter times the sync delay, then the fixed sync pulse length.
  assign sync_load = (vid_rise && cfg.sync_dly == '0) || (vid_rise && cfg.sync_dly != '0) ||
                     (sync_wait_q && sync_done);
  assign sync_val = (vid_rise && cfg.sync_dly != '0) ? cfg.sync_dly : SYNC_PULSE_U;
  assign video_d = ext_mode ? trigger_input : (trig_mode && st_d == TPG_PULSE);

  // Counters step two 10 ns units per 20 ns clock, so settings stay exact in units.
  tpg_counter #(.W(VAL_W), .STEP(TICK_UNITS)) u_main_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .load(main_load),
    .load_val(main_val),
    .run(st_q != TPG_IDLE),
    .rem(main_rem),
    .done(main_done)
  );

  tpg_counter #(.W(VAL_W), .STEP(TICK_UNITS)) u_sync_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .load(sync_load),
    .load_val(sync_val),
    .run(sync_busy),
    .rem(sync_rem),
    .done(sync_done)
  );

  // Engine registers and outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= TPG_IDLE;
      trig_prev_q <= 1'b0;
      video_q <= 1'b0;
      mod_status_q <= 1'b0;
    end else begin
      st_q <= st_d;
      trig_prev_q <= trigger_input;
      video_q <= video_d;
      mod_status_q <= cfg.mod_en;
    end
  end

  // Sync phase: zero delay raises sync with the video edge, else it waits its delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_wait_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (!trig_mode) begin
      sync_wait_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (vid_rise) begin
      sync_wait_q <= (cfg.sync_dly != '0);
      sync_q <= (cfg.sync_dly == '0);
    end else if (sync_wait_q && sync_done) begin
      sync_wait_q <= 1'b0;
      sync_q <= 1'b1;
    end else if (sync_q && sync_done) begin
      sync_q <= 1'b0;
    end
  end

  // Missed-trigger flag: write one to clear, but a new miss in that cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_q <= 1'b0;
    end else if (missed) begin
      miss_q <= 1'b1;
    end else if (wr && hit_stat && pwdata[STAT_MISS_BIT]) begin
      miss_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign video_pulse_output = video_q;
  assign sync_pulse_output = sync_q;
  assign modulation_status = mod_status_q;

  // Checking helpers: cycles since the last interval start and the setting it was timed against.
  logic [VAL_W-1:0] hcnt_q, hval_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= '0;
      hval_q <= '0;
    end else if (main_load) begin
      hcnt_q <= VAL_W'(1);
      hval_q <= main_val;
    end else begin
      hcnt_q <= hcnt_q + VAL_W'(1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  trig_edge_sel_a: assert property (accept |-> (cfg.fall_edge ? (!trigger_input && trig_prev_q)
                                                 : (trigger_input && !trig_prev_q)))
    else $error("Trigger accepted on the wrong edge.");

  one_pulse_a: assert property (accept |=> st_q == TPG_DELAY ##0 !video_q)
    else $error("Accepted trigger did not start exactly one delay phase.");

  delay_time_a: assert property (($rose(video_q) && $past(trig_mode) && trig_mode) |->
                                 $past(hcnt_q) == ($past(hval_q) + VAL_W'(TICK_UNITS - 1)) / VAL_W'(TICK_UNITS))
    else $error("Trigger to video delay is wrong.");

  width_time_a: assert property (($fell(video_q) && $past(st_q) == TPG_PULSE && trig_mode) |->
                                 $past(hcnt_q) == ($past(hval_q) + VAL_W'(TICK_UNITS - 1)) / VAL_W'(TICK_UNITS))
    else $error("Video pulse width is wrong.");

  sync_zero_a: assert property (($rose(video_q) && trig_mode && $past(cfg.sync_dly) == '0) |-> sync_q)
    else $error("Zero sync delay did not raise sync with video.");

  sync_after_a: assert property ($rose(sync_q) |-> video_q || $past(sync_wait_q))
    else $error("Sync rose without a video pulse leading it.");

  setting_range_a: assert property ({5'h00, dly_q} >= DLY_LO && {5'h00, syn_q} <= SYN_HI &&
                                    {5'h00, dst_q} <= 32'(DSTEP_MAX_U) && {5'h00, wid_q} >= WID_LO)
    else $error("A setting left its range.");

  mode_switch_a: assert property ((cfg.mod_en && cfg.mode == TPG_MODE_CONT) |=>
                                  st_q == TPG_IDLE && !sync_q && !video_q)
    else $error("Engine kept running after a mode change.");

  status_off_a: assert property ($fell(en_q) |-> ##1 (!mod_status_q && !video_q) [*2])
    else $error("Modulation status or output stayed up after disable.");

  apb_ready_a: assert property ((psel && penable && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("APB access did not finish after one wait state.");

endmodule

// ==== test/tpg_partner.sv ====
// Trigger source and pulse observer standing at the far side of the generator.
module tpg_partner (
  // Clock.
  input wire logic pclk,
  // Pulses from the generator.
  input wire logic video,
  input wire logic sync,
  // Trigger to the generator.
  output logic trig
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  int t_trig = 0;
  int v_rise = 0;
  int v_fall = 0;
  int s_rise = 0;
  int s_fall = 0;
  int pulses = 0;
  logic last_t = 1'b0;
  logic last_v = 1'b0;
  logic last_s = 1'b0;

  // The trigger idles low until the bench asks for an edge.
  initial begin
    trig = 1'b0;
  end

  // Cycle count advances on the same edge that launches every output change.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
  end

  // Edges are logged at the falling edge, where every registered output has settled.
  always @(negedge pclk) begin
    if (trig !== last_t) t_trig = cyc;
    if (video === 1'b1 && last_v !== 1'b1) begin
      v_rise = cyc;
      pulses++;
    end
    if (video !== 1'b1 && last_v === 1'b1) v_fall = cyc;
    if (sync === 1'b1 && last_s !== 1'b1) s_rise = cyc;
    if (sync !== 1'b1 && last_s === 1'b1) s_fall = cyc;
    last_t = trig;
    last_v = video;
    last_s = sync;
  end

  // A TTL source changes its level right after a clock edge, never mid-cycle.
  task drive(input logic v);
    @(posedge pclk);
    trig <= v;
  endtask
endmodule

// ==== test/tb_triggered_pulse_generator.sv ====
// Self-checking bench for the triggered pulse generator over APB and its pulse pins.
module tb_triggered_pulse_generator import tpg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trigger_input;
  logic video_pulse_output;
  logic sync_pulse_output;
  logic modulation_status;
  int errors = 0;
  int tests_run = 0;

  // Short maxima keep the clamping limits small without touching the step logic.
  tpg_top #(.DELAY_MAX_NS_P(2000), .WIDTH_MAX_NS_P(1000), .SYNC_MAX_NS_P(1000)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_input(trigger_input), .video_pulse_output(video_pulse_output),
    .sync_pulse_output(sync_pulse_output), .modulation_status(modulation_status));

  tpg_partner u_par (.pclk(pclk), .video(video_pulse_output), .sync(sync_pulse_output),
    .trig(trigger_input));

  // A 50 MHz clock that starts low, so the first rising edge falls at 10 ns.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("Counts: %0d comparisons, %0d errors", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(rd, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  // Edge to video rise is one sampling edge plus half the delay units, rounded up.
  task automatic pulse_chk(input logic lvl, input int d, input int w, input int s);
    int p;
    p = u_par.pulses;
    u_par.drive(lvl);
    repeat (d / 2 + w / 2 + s / 2 + 14) @(posedge pclk);
    chk(32'(u_par.pulses - p), 32'h1);
    chk(32'(u_par.v_rise - u_par.t_trig), 32'(1 + (d + 1) / 2));
    chk(32'(u_par.v_fall - u_par.v_rise), 32'((w + 1) / 2));
    chk(32'(u_par.s_rise - u_par.v_rise), 32'((s + 1) / 2));
    chk(32'(u_par.s_fall - u_par.s_rise), 32'h5);
  endtask

  task automatic none_chk(input logic lvl);
    int p;
    p = u_par.pulses;
    u_par.drive(lvl);
    repeat (40) @(posedge pclk);
    chk(32'(u_par.pulses - p), 32'h0);
  endtask

  // A hung handshake must not stall the run forever.
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end

  // Main sequence.
  initial begin
    logic [31:0] rd;
    logic e;
    // The bus idles and reset is asserted from time zero, not tied by declaration.
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFF_CTRL, 32'h00000004, 1'b0);
    rchk(OFF_STATUS, 32'h00000000, 1'b0);
    rchk(OFF_DELAY, 32'h0000000A, 1'b0);
    rchk(OFF_WIDTH, 32'h00000064, 1'b0);
    rchk(OFF_SYNC, 32'h00000000, 1'b0);
    rchk(OFF_DSTEP, 32'h00000001, 1'b0);
    rchk(OFF_WSTEP, 32'h00000001, 1'b0);
    rchk(OFF_SSTEP, 32'h00000001, 1'b0);
    rchk(8'h40, 32'h00000000, 1'b1);
    apb(1'b1, 8'h44, 32'h00000007, rd, e);
    chk({31'h0, e}, 32'h1);
    // Rising edge, shortest delay, sync coinciding with video.
    wr(OFF_WIDTH, 32'h00000005);
    wr(OFF_CTRL, 32'h00000005);
    rchk(OFF_STATUS, 32'h00000001, 1'b0);
    pulse_chk(1'b1, 10, 5, 0);
    none_chk(1'b0);
    // Falling edge with odd unit counts exercises the 20 ns rounding.
    wr(OFF_CTRL, 32'h0000000D);
    wr(OFF_DELAY, 32'h0000000B);
    wr(OFF_WIDTH, 32'h00000007);
    wr(OFF_SYNC, 32'h00000003);
    rchk(OFF_DELAY, 32'h0000000B, 1'b0);
    none_chk(1'b1);
    pulse_chk(1'b0, 11, 7, 3);
    // A second accepted-direction edge inside the delay is dropped and flagged.
    wr(OFF_DELAY, 32'h00000028);
    begin
      int p;
      p = u_par.pulses;
      u_par.drive(1'b1);
      u_par.drive(1'b0);
      u_par.drive(1'b1);
      u_par.drive(1'b0);
      rchk(OFF_STATUS, 32'h00000013, 1'b0);
      repeat (60) @(posedge pclk);
      chk(32'(u_par.pulses - p), 32'h1);
    end
    rchk(OFF_STATUS, 32'h00000011, 1'b0);
    wr(OFF_STATUS, 32'h00000010);
    rchk(OFF_STATUS, 32'h00000001, 1'b0);
    // Switching mode in mid-delay must cancel the pending pulse at once.
    u_par.drive(1'b1);
    begin
      int p;
      p = u_par.pulses;
      u_par.drive(1'b0);
      wr(OFF_CTRL, 32'h00000003);
      repeat (40) @(posedge pclk);
      chk(32'(u_par.pulses - p), 32'h0);
    end
    chk({31'h0, modulation_status}, 32'h1);
    // External mode passes the trigger straight through.
    wr(OFF_CTRL, 32'h00000001);
    u_par.drive(1'b1);
    repeat (3) @(posedge pclk);
    chk({31'h0, video_pulse_output}, 32'h1);
    u_par.drive(1'b0);
    repeat (3) @(posedge pclk);
    chk({31'h0, video_pulse_output}, 32'h0);
    // Disabled triggered mode produces nothing and drops the status.
    wr(OFF_CTRL, 32'h00000004);
    rchk(OFF_STATUS, 32'h00000000, 1'b0);
    chk({31'h0, modulation_status}, 32'h0);
    none_chk(1'b1);
    u_par.drive(1'b0);
    // Width survives the mode changes; steps move each setting by its own increment.
    rchk(OFF_WIDTH, 32'h00000007, 1'b0);
    wr(OFF_DSTEP, 32'h00000004);
    wr(OFF_STEPCMD, 32'h00000000);
    rchk(OFF_DELAY, 32'h0000002C, 1'b0);
    wr(OFF_WSTEP, 32'h00000002);
    wr(OFF_STEPCMD, 32'h00000005);
    rchk(OFF_WIDTH, 32'h00000005, 1'b0);
    wr(OFF_STEPCMD, 32'h00000002);
    rchk(OFF_SYNC, 32'h00000004, 1'b0);
    rchk(OFF_STEPCMD, 32'h00000000, 1'b0);
    wr(OFF_DELAY, 32'h00000005);
    rchk(OFF_DELAY, 32'h0000000A, 1'b0);
    wr(OFF_WIDTH, 32'h00000000);
    rchk(OFF_WIDTH, 32'h00000005, 1'b0);
    complete_run();
  end
endmodule
